// *** src/spc_pkg.sv ***
package spc_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;

  // Status register bit positions.
  localparam int unsigned B_TCF  = 7;
  localparam int unsigned B_WCOL = 6;
  localparam int unsigned B_OVR  = 5;
  localparam int unsigned B_MODE_FAULT_FLAG = 4;
  localparam int unsigned B_SSM  = 1;
  localparam int unsigned B_SSI  = 0;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // ----------------------------------------
  // Timing constants
  // ----------------------------------------
  localparam int unsigned SYNC_N = 2;
  localparam logic [3:0]  LAST_EDGE = 4'hF;
  localparam logic [7:0]  DIV_4   = 8'h04;
  localparam logic [7:0]  DIV_8   = 8'h08;
  localparam logic [7:0]  DIV_16  = 8'h10;
  localparam logic [7:0]  DIV_32  = 8'h20;
  localparam logic [7:0]  DIV_64  = 8'h40;
  localparam logic [7:0]  DIV_128 = 8'h80;

  // Control register fields, in their bit order 7..0.
  typedef struct packed {
    logic       irq_en;
    logic       out_en;
    logic       div2_n;
    logic       master;
    logic       idle_lvl;
    logic       phase;
    logic [1:0] rate;
  } spc_ctrl_s;

  typedef enum logic {
    SPC_IDLE  = 1'b0,
    SPC_SHIFT = 1'b1
  } spc_state_e;

  // Selects the master divider from {divide_two_enable_n, rate}.
  function automatic logic [7:0] spc_div(input logic [2:0] sel);
    case (sel)
      3'h4:    spc_div = DIV_4;
      3'h0:    spc_div = DIV_8;
      3'h1:    spc_div = DIV_16;
      3'h6:    spc_div = DIV_32;
      3'h2:    spc_div = DIV_64;
      3'h3:    spc_div = DIV_128;
      default: spc_div = DIV_8;
    endcase
  endfunction : spc_div

endpackage : spc_pkg

// *** src/spc_serial_port.sv ***
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - Software-managed select ignores pin, uses level bit
// - Phase-zero slave flags write collision
// - Enabled interrupt on complete, fault, overrun
// - Output enable connects pins, reset clears
// - Mode fault clears output enable and master
// - Master drives clock, swaps data pins
// - Polarity bit sets clock idle level
// - Phase bit picks first capture edge
// - Master clock divided per divider bits
// - Divider bits ignored in slave mode
module spc_serial_port
  import spc_pkg::*;
(
  // Clock, reset and enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Serial pins
  input  wire logic              sck_i,
  output logic                   sck_o,
  output logic                   sck_oe,
  input  wire logic              mosi_i,
  output logic                   mosi_o,
  output logic                   mosi_oe,
  input  wire logic              miso_i,
  output logic                   miso_o,
  output logic                   miso_oe,
  input  wire logic              ss_n_i,
  // Interrupt request
  output logic                   irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  spc_ctrl_s   ctrl_r;
  spc_state_e  state_r;
  logic        tcf_r, wcol_r, ovr_r, mode_fault_flag_r, ssm_r, ssi_r;
  logic [7:0]  sh_r, rx_r;
  logic        out_r, sck_r, raised_r;
  logic [3:0]  cnt_r;
  logic [5:0]  hcnt_r;
  logic [SYNC_N-1:0] sck_sy_r, mosi_sy_r, miso_sy_r, ss_sy_r;
  logic        sck_d_r;
  logic        aw_rdy_r, w_rdy_r, ar_rdy_r;
  logic        m_cap_r, m_fin_r;

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------
  logic        ss_int, slave_act, act, m_edge, s_edge, edge_ev, capture;
  logic        in_bit, done, mode_fault_flag_ev, wr, wr_ctrl, wr_stat, wr_data, wcol_ev;
  logic        load, start, shift_now, fin;
  logic [7:0]  byte_fin, stat_rd;
  logic [5:0]  half_m1;

  // Internal select level comes from the level bit under software management.
  assign ss_int    = ssm_r ? ssi_r : ss_sy_r[SYNC_N-1];
  assign slave_act = ctrl_r.out_en & ~ctrl_r.master & ~ss_int;
  assign act       = ctrl_r.master ? (state_r == SPC_SHIFT) : slave_act;
  assign m_edge    = (state_r == SPC_SHIFT) && (hcnt_r == 6'h00);
  assign s_edge    = slave_act && (sck_sy_r[SYNC_N-1] != sck_d_r);
  assign edge_ev   = ctrl_r.master ? m_edge : s_edge;
  // Even edges capture in phase zero, odd edges in phase one.
  assign capture   = (cnt_r[0] == ctrl_r.phase);
  assign in_bit    = ctrl_r.master ? miso_sy_r[SYNC_N-1] : mosi_sy_r[SYNC_N-1];
  assign done      = edge_ev && (cnt_r == LAST_EDGE);
  // The master shifts one cycle after its capture edge, so that the bit echoed
  // back through the pin synchroniser has arrived even at the fastest divider.
  assign shift_now = ctrl_r.master ? m_cap_r : (edge_ev & capture);
  // A second-edge master completes once its delayed last capture has landed.
  assign fin       = (done & ~(ctrl_r.master & ctrl_r.phase)) | m_fin_r;
  assign byte_fin  = shift_now ? {sh_r[6:0], in_bit} : sh_r;
  // A low select seen while master is a mode fault.
  assign mode_fault_flag_ev   = ctrl_r.master & ~ss_int;
  // Divider bits only matter in master mode; the slave follows the pin clock.
  assign half_m1   = 6'(spc_div({ctrl_r.div2_n, ctrl_r.rate}) >> 1) - 6'h01;

  assign wr      = aw_rdy_r & s_axi_awvalid & w_rdy_r & s_axi_wvalid;
  assign wr_ctrl = wr && (s_axi_awaddr == OFS_CTRL) && s_axi_wstrb[0];
  assign wr_stat = wr && (s_axi_awaddr == OFS_STAT) && s_axi_wstrb[0];
  assign wr_data = wr && (s_axi_awaddr == OFS_DATA) && s_axi_wstrb[0];
  // Writing the shift register mid-byte, or before select was raised in phase zero.
  assign wcol_ev = wr_data & ((state_r == SPC_SHIFT) | (cnt_r != 4'h0) |
                   (~ctrl_r.master & ~ctrl_r.phase & ~raised_r));
  assign load    = wr_data & ~wcol_ev;
  assign start   = load & ctrl_r.master & ctrl_r.out_en;

  always_comb
  begin
    stat_rd         = 8'h00;
    stat_rd[B_TCF]  = tcf_r;
    stat_rd[B_WCOL] = wcol_r;
    stat_rd[B_OVR]  = ovr_r;
    stat_rd[B_MODE_FAULT_FLAG] = mode_fault_flag_r;
    stat_rd[B_SSM]  = ssm_r;
    stat_rd[B_SSI]  = ssi_r;
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Every pin input passes two flip-flops; the edge detector reads the second.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_sy_r  <= '0;
      mosi_sy_r <= '0;
      miso_sy_r <= '0;
      ss_sy_r   <= '1;
      sck_d_r   <= 1'b0;
    end
    else if (ce)
    begin
      sck_sy_r  <= {sck_sy_r[SYNC_N-2:0], sck_i};
      mosi_sy_r <= {mosi_sy_r[SYNC_N-2:0], mosi_i};
      miso_sy_r <= {miso_sy_r[SYNC_N-2:0], miso_i};
      ss_sy_r   <= {ss_sy_r[SYNC_N-2:0], ss_n_i};
      sck_d_r   <= sck_sy_r[SYNC_N-1];
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Control register; a mode fault drops output enable and master select.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_r <= spc_ctrl_s'(CTRL_RST);
    else if (ce)
    begin
      if (wr_ctrl)
        ctrl_r <= spc_ctrl_s'(s_axi_wdata[7:0]);
      if (mode_fault_flag_ev)
      begin
        ctrl_r.out_en <= 1'b0;
        ctrl_r.master <= 1'b0;
      end
    end
  end

  // Select management bits and sticky flags; a set wins over a clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ssm_r  <= 1'b0;
      ssi_r  <= 1'b0;
      tcf_r  <= 1'b0;
      wcol_r <= 1'b0;
      ovr_r  <= 1'b0;
      mode_fault_flag_r <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_stat)
      begin
        ssm_r <= s_axi_wdata[B_SSM];
        ssi_r <= s_axi_wdata[B_SSI];
      end
      tcf_r  <= fin | (tcf_r & ~(wr_stat & s_axi_wdata[B_TCF]));
      wcol_r <= wcol_ev | (wcol_r & ~(wr_stat & s_axi_wdata[B_WCOL]));
      ovr_r  <= (fin & tcf_r) | (ovr_r & ~(wr_stat & s_axi_wdata[B_OVR]));
      mode_fault_flag_r <= mode_fault_flag_ev | (mode_fault_flag_r & ~(wr_stat & s_axi_wdata[B_MODE_FAULT_FLAG]));
    end
  end

  // Received byte; while the complete flag is set the old byte is kept and the new one is lost to overrun.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_r <= 8'h00;
    else if (ce && fin && !tcf_r)
      rx_r <= byte_fin;
  end

  // Tracks whether select went high since the last slave byte.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      raised_r <= 1'b1;
    else if (ce)
    begin
      if (ss_int)
        raised_r <= 1'b1;
      else if (done)
        raised_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  // Master sequencing: runs one byte, stops on completion or mode fault.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_r <= SPC_IDLE;
    else if (ce)
    begin
      case (state_r)
        SPC_IDLE:  if (start) state_r <= SPC_SHIFT;
        SPC_SHIFT: if (done || mode_fault_flag_ev || !ctrl_r.out_en) state_r <= SPC_IDLE;
        default:   state_r <= SPC_IDLE;
      endcase
    end
  end

  // Half-period counter and master clock; idle level held outside a byte.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hcnt_r <= 6'h00;
      sck_r  <= 1'b0;
    end
    else if (ce)
    begin
      if (state_r != SPC_SHIFT)
      begin
        hcnt_r <= half_m1;
        sck_r  <= ctrl_r.idle_lvl;
      end
      else if (m_edge)
      begin
        hcnt_r <= half_m1;
        sck_r  <= ~sck_r;
      end
      else
        hcnt_r <= hcnt_r - 6'h01;
    end
  end

  // Edge counter; sixteen clock edges make one byte.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_r <= 4'h0;
    else if (ce)
    begin
      if (!act || done)
        cnt_r <= 4'h0;
      else if (edge_ev)
        cnt_r <= cnt_r + 4'h1;
    end
  end

  // Delayed master capture and completion strobes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      m_cap_r <= 1'b0;
      m_fin_r <= 1'b0;
    end
    else if (ce)
    begin
      m_cap_r <= ctrl_r.master & edge_ev & capture;
      m_fin_r <= ctrl_r.master & ctrl_r.phase & done;
    end
  end

  // Shift register and outgoing bit: capture edges shift in, launch edges drive out.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sh_r  <= 8'h00;
      out_r <= 1'b0;
    end
    else if (ce)
    begin
      if (load)
      begin
        sh_r  <= s_axi_wdata[7:0];
        out_r <= s_axi_wdata[7];
      end
      else if (shift_now)
        sh_r <= {sh_r[6:0], in_bit};
      else if (edge_ev && !capture)
        out_r <= sh_r[7];
    end
  end

  // ----------------------------------------
  // Pin drivers and interrupt
  // ----------------------------------------
  // Master drives clock and MOSI; a selected slave drives MISO.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_oe  <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
      irq     <= 1'b0;
    end
    else if (ce)
    begin
      sck_oe  <= ctrl_r.out_en & ctrl_r.master;
      mosi_oe <= ctrl_r.out_en & ctrl_r.master;
      miso_oe <= slave_act;
      irq     <= ctrl_r.irq_en & (tcf_r | mode_fault_flag_r | ovr_r);
    end
  end

  assign sck_o  = sck_r;
  assign mosi_o = out_r;
  assign miso_o = out_r;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  // Address and data are taken together in one cycle; response follows.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_rdy_r     <= 1'b0;
      w_rdy_r      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end
    else if (ce)
    begin
      aw_rdy_r <= s_axi_awvalid & s_axi_wvalid & ~aw_rdy_r & ~s_axi_bvalid;
      w_rdy_r  <= s_axi_awvalid & s_axi_wvalid & ~w_rdy_r & ~s_axi_bvalid;
      if (wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (s_axi_awaddr == OFS_CTRL || s_axi_awaddr == OFS_STAT ||
                         s_axi_awaddr == OFS_DATA) ? RESP_OK : RESP_ERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read path; unmapped addresses read zero with an error response.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ar_rdy_r     <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OK;
    end
    else if (ce)
    begin
      ar_rdy_r <= s_axi_arvalid & ~ar_rdy_r & ~s_axi_rvalid;
      if (ar_rdy_r && s_axi_arvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OK;
        case (s_axi_araddr)
          OFS_CTRL: s_axi_rdata <= {24'h000000, ctrl_r};
          OFS_STAT: s_axi_rdata <= {24'h000000, stat_rd};
          OFS_DATA: s_axi_rdata <= {24'h000000, rx_r};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_ERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_awready = aw_rdy_r;
  assign s_axi_wready  = w_rdy_r;
  assign s_axi_arready = ar_rdy_r;

endmodule : spc_serial_port

// *** verif/spc_props.sv ***
`timescale 1ns/1ps
module spc_props
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  // Serial pins and interrupt
  input wire logic              sck_o,
  input wire logic              sck_oe,
  input wire logic              mosi_oe,
  input wire logic              miso_oe,
  input wire logic              ss_n_i,
  input wire logic              irq
);
  logic       irq_en_s, idle_s, ssm_s, ssi_s, sck_d, wr_hs;
  logic [7:0] sck_gap, cw_gap;

  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wstrb[0];

  // Shadows the control and select bits from accepted bus writes.
  always_ff @(posedge aclk)
    if (!aresetn)
      {irq_en_s, idle_s, ssm_s, ssi_s} <= 4'h0;
    else if (wr_hs && s_axi_awaddr == OFS_CTRL)
      {irq_en_s, idle_s} <= {s_axi_wdata[7], s_axi_wdata[3]};
    else if (wr_hs && s_axi_awaddr == OFS_STAT)
      {ssm_s, ssi_s} <= s_axi_wdata[1:0];

  // Counts quiet cycles of the serial clock and cycles since a control write.
  always_ff @(posedge aclk)
  begin
    sck_d <= sck_o;
    if (!aresetn || sck_o != sck_d) sck_gap <= 8'h00;
    else if (sck_gap != 8'hFF) sck_gap <= sck_gap + 8'h01;
    if (!aresetn || (wr_hs && s_axi_awaddr == OFS_CTRL)) cw_gap <= 8'h00;
    else if (cw_gap != 8'hFF) cw_gap <= cw_gap + 8'h01;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_fault;
    !ssm_s && !ss_n_i && sck_oe;
  endsequence

  chk_oe_reset: assert property ($rose(aresetn) |-> !sck_oe && !mosi_oe && !miso_oe)
    else $error("Serial pins driven right after reset.");
  chk_master_pins: assert property (sck_oe |-> mosi_oe && !miso_oe)
    else $error("Master drives the wrong data pin.");
  chk_slave_pins: assert property (!sck_oe |-> !mosi_oe)
    else $error("Slave drives the master data pin.");
  chk_mode_fault: assert property (s_fault |-> ##[1:8] !sck_oe)
    else $error("Select low in master mode did not disable the port.");
  chk_sw_select: assert property ($fell(sck_oe) && cw_gap > 8'h04 |-> !(ssm_s && ssi_s))
    else $error("Pin select acted while software select was high.");
  chk_irq_masked: assert property ((!irq_en_s) [*3] |-> !irq)
    else $error("Interrupt raised while disabled.");
  chk_clk_idle: assert property (sck_gap == 8'h96 |-> sck_o == idle_s)
    else $error("Quiet serial clock not at its idle level.");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write response dropped before it was taken.");
endmodule : spc_props

// *** verif/spc_peer.sv ***
`timescale 1ns/1ps
module spc_peer (
  // Lines from the master
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       act,
  // Reply line and captured byte
  output logic            miso,
  output logic [7:0]      rx
);
  logic [7:0] tx = 8'hA5;
  logic [2:0] n  = 3'h0;

  // Captures on the rising edge: idle low, first-edge capture like the master.
  always @(posedge sck) if (act) rx <= {rx[6:0], mosi};

  // Shifts on the falling edge and reloads after the eighth bit.
  always @(negedge sck)
    if (act)
    begin
      n  <= n + 3'h1;
      tx <= (n == 3'h7) ? 8'hA5 : {tx[6:0], 1'b0};
    end

  // A released line shows the inverse of its last value.
  assign miso = act ? tx[7] : ~tx[7];
endmodule : spc_peer

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import spc_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, sck_i = 1'b0, mosi_i = 1'b0, ss_n_i = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, miso_i;
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, sp = 1'b0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [7:0]  prx, mb, sb = 8'h5A;
  logic [2:0]  sel [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
  int          dv [6] = '{4, 8, 16, 32, 64, 128};
  int          fail_count = 0, tests_run = 0, tg = 0, t0 = 0, t1 = 0, cyc = 0;

  spc_serial_port u_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_i, .sck_o,
    .sck_oe, .mosi_i, .mosi_o, .mosi_oe, .miso_i, .miso_o, .miso_oe, .ss_n_i, .irq);
  spc_peer u_peer (.sck(sck_o), .mosi(mosi_o), .act(mosi_oe), .miso(miso_i), .rx(prx));

  // Runs the 250 MHz clock.
  initial forever #2 aclk = ~aclk;

  // Logs serial clock toggles with their cycle numbers.
  always @(posedge aclk)
  begin
    cyc++;
    sp <= sck_o;
    if (sck_o !== sp)
    begin
      if (tg == 0) t0 = cyc;
      t1 = cyc;
      tg++;
    end
  end

  // Writes one register and keeps the response code.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, 24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do @(posedge aclk); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // Reads one register and keeps data and response code.
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    {rv, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd

  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops.
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  // Cuts a hang short.
  initial
  begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    summarize();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CTRL);
    chk(rv, 32'h0);
    rd(4'hC);
    chk({rv[29:0], rs}, {30'h0, RESP_ERR});
    wr(4'hC, 8'hFF);
    chk({30'h0, rs}, {30'h0, RESP_ERR});
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_CTRL, {2'h3, sel[i][2], 1'b1, 2'h0, sel[i][1:0]});
      tg = 0;
      wr(OFS_DATA, 8'h3C);
      for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge aclk);
      chk(tg, 16);
      chk(t1 - t0, 15 * dv[i] / 2);
      chk({24'h0, prx}, 32'h3C);
      rd(OFS_DATA);
      chk(rv, 32'hA5);
      rd(OFS_STAT);
      chk(rv, 32'h80);
      wr(OFS_STAT, 8'h80);
    end
    $display("test divider done");
    wr(OFS_CTRL, 8'h08);
    repeat (160) @(posedge aclk);
    chk({31'h0, sck_o}, 32'h1);
    wr(OFS_CTRL, 8'h5C);
    repeat (4) @(posedge aclk);
    chk({28'h0, sck_o, sck_oe, mosi_oe, miso_oe}, 32'hE);
    rd(OFS_CTRL);
    chk(rv, 32'h5C);
    wr(OFS_CTRL, 8'h08);
    wr(OFS_CTRL, 8'h00);
    repeat (4) @(posedge aclk);
    chk({30'h0, sck_o, sck_oe}, 32'h0);
    $display("test pins done");
    wr(OFS_STAT, 8'h03);
    wr(OFS_CTRL, 8'hD0);
    ss_n_i <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(OFS_CTRL);
    chk(rv, 32'hD0);
    wr(OFS_STAT, 8'h00);
    repeat (10) @(posedge aclk);
    rd(OFS_CTRL);
    chk(rv, 32'h80);
    rd(OFS_STAT);
    chk(rv, 32'h10);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_CTRL, 8'h00);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    ss_n_i <= 1'b1;
    wr(OFS_STAT, 8'h10);
    rd(OFS_STAT);
    chk(rv, 32'h0);
    $display("test select done");
    wr(OFS_CTRL, 8'h40);
    wr(OFS_DATA, 8'h96);
    ss_n_i <= 1'b0;
    for (int b = 7; b >= 0; b--)
    begin
      mosi_i <= sb[b];
      repeat (8) @(posedge aclk);
      mb[b] = miso_o;
      sck_i <= 1'b1;
      repeat (8) @(posedge aclk);
      sck_i <= 1'b0;
    end
    repeat (8) @(posedge aclk);
    chk({31'h0, miso_oe}, 32'h1);
    chk({24'h0, mb}, 32'h96);
    rd(OFS_DATA);
    chk(rv, 32'h5A);
    wr(OFS_DATA, 8'h00);
    rd(OFS_STAT);
    chk(rv, 32'hC0);
    ss_n_i <= 1'b1;
    $display("test slave done");
    summarize();
  end
endmodule : tb_top

bind spc_serial_port spc_props u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .sck_o, .sck_oe, .mosi_oe, .miso_oe, .ss_n_i, .irq);
